/* File: src/otd_debug_trace.sv */
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Eight-deep queue captures addresses or data bytes.
// - Two 16-bit comparators with direction qualification.
// - Execution qualification triggers only on executed opcodes.
// - Greater/less magnitude tests for range modes.
// - Background controller accesses never produce matches.
// - A on address; B on address or data.
// - Full modes use write bus if A qualifies write.
// - Match breaks, stores data, starts or stops trace.
// - Queue reports valid count; host does dummy reads.
// - High byte first; low byte read shifts queue.
// - Event modes store bytes, low read shifts.
// - Flow changes at start trigger plus two skipped.
// - End trace stores triggering flow change last.
// - Unarmed low read pushes last fetched opcode address.
// - Taken conditional branch stores branch opcode address.
// - Indirect jump and call store computed destination.
// - Interrupt and returns store destination address.
// - Force break lets instruction finish first.
// - Tag break marks opcode entering instruction queue.
// - Separate execution tracking for each comparator.
// - Mode field picks nine modes; begin chooses.
// - Arm sets run flag, clears flags, count.
module otd_debug_trace
  import otd_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  // Classic Wishbone slave.
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic             o_wb_ack,
  output logic      [31:0] o_wb_dat,
  // CPU core side, same clock.
  input  wire logic        i_cpu_bus_valid,
  input  wire logic [15:0] i_cpu_addr,
  input  wire logic        i_cpu_read,
  input  wire logic [7:0]  i_cpu_rd_data,
  input  wire logic [7:0]  i_cpu_wr_data,
  input  wire logic        i_bdc_access,
  input  wire logic        i_opcode_fetch,
  input  wire logic        i_opcode_exec,
  input  wire logic        i_queue_flush,
  input  wire logic [15:0] i_opcode_addr,
  input  wire logic        i_cof_valid,
  input  wire logic [1:0]  i_cof_kind,
  input  wire logic [15:0] i_index_pair,
  input  wire logic [15:0] i_cof_dest,
  // Breakpoint requests to the CPU core and the registered run flag.
  output logic             o_brk_force,
  output logic             o_brk_tag,
  output logic             o_run_active
);

  // Software-visible configuration and flags, then internal capture state.
  logic [15:0] cmp_a;                  // Comparator A value.
  logic [15:0] cmp_b;                  // Comparator B value.
  logic [7:0]  control;                // Break, tag and direction controls; arm bit unused here.
  logic [7:0]  trigger_config_reg;     // Execution select, begin and mode.
  logic        run_active_flag;        // The run is armed.
  logic        a_flag;                 // Comparator A has matched since arming.
  logic        b_flag;                 // Comparator B has matched since arming.
  otd_run_t    run_state;              // Capture engine state.
  logic [1:0]  holdoff;                // Bus cycles still skipped after a begin trigger.
  logic [15:0] last_fetch_addr;        // Address of the most recently fetched opcode.

  // Field views.
  logic [3:0]  trigger_mode_field;
  logic        exec_qualify_select;
  logic        begin_sel;
  logic        cmp_a_dir_qual_en;
  logic        cmp_a_dir_value;
  logic        cmp_b_dir_qual_en;
  logic        cmp_b_dir_value;
  logic        brk_en;
  logic        brk_tag_sel;

  assign trigger_mode_field  = trigger_config_reg[TCF_MODE_MSB:0];
  assign exec_qualify_select = trigger_config_reg[TCF_EXEC_QUAL_BIT];
  assign begin_sel           = trigger_config_reg[TCF_BEGIN_BIT];
  assign cmp_a_dir_qual_en   = control[CTL_A_DIR_EN];
  assign cmp_a_dir_value     = control[CTL_A_DIR_VAL];
  assign cmp_b_dir_qual_en   = control[CTL_B_DIR_EN];
  assign cmp_b_dir_value     = control[CTL_B_DIR_VAL];
  assign brk_en              = control[CTL_BRK_EN_BIT];
  assign brk_tag_sel         = control[CTL_TAG_BIT];

  // Bus decode. Writes and pops act at the edge where the master sees ack.
  logic       bus_req;
  logic       bus_done;
  logic       wr_lane;
  logic [5:0] word;
  logic       wr_cmp_a_hi;
  logic       wr_cmp_a_lo;
  logic       wr_cmp_b_hi;
  logic       wr_cmp_b_lo;
  logic       wr_control;
  logic       wr_trigger;
  logic       rd_queue_lo;
  logic       arm_write;
  logic       disarm_write;

  assign bus_req      = i_wb_cyc && i_wb_stb;
  assign bus_done     = bus_req && o_wb_ack;
  assign wr_lane      = bus_done && i_wb_we && i_wb_sel[0];
  assign word         = i_wb_adr[7:2];
  assign wr_cmp_a_hi  = wr_lane && word == OFF_CMP_A_HI[7:2];
  assign wr_cmp_a_lo  = wr_lane && word == OFF_CMP_A_LO[7:2];
  assign wr_cmp_b_hi  = wr_lane && word == OFF_CMP_B_HI[7:2];
  assign wr_cmp_b_lo  = wr_lane && word == OFF_CMP_B_LO[7:2];
  assign wr_control   = wr_lane && word == OFF_CONTROL[7:2];
  assign wr_trigger   = wr_lane && word == OFF_TRIGGER_CFG[7:2];
  // The high byte read has no side effect; only a finished low byte read shifts.
  assign rd_queue_lo  = bus_done && !i_wb_we && word == OFF_QUEUE_LO[7:2];
  assign arm_write    = wr_control && i_wb_dat[CTL_ARM_BIT];
  assign disarm_write = wr_control && !i_wb_dat[CTL_ARM_BIT];

  // Mode classes.
  logic event_mode;
  logic full_mode;
  assign event_mode = trigger_mode_field == MODE_EVENT_B || trigger_mode_field == MODE_A_THEN_EVT_B;
  assign full_mode  = trigger_mode_field == MODE_A_AND_B_DATA || trigger_mode_field == MODE_A_NOT_B_DATA;

  // Comparators. Every background-controller access is masked out.
  logic       cmp_enable;
  logic       dir_ok_a;
  logic       dir_ok_b;
  logic [7:0] data_sel;
  logic       eq_a;
  logic       eq_b;
  logic       eq_b_data;
  logic       ge_a;
  logic       le_b;
  logic       cond_a;
  logic       cond_b;

  assign cmp_enable = i_cpu_bus_valid && !i_bdc_access;
  assign dir_ok_a   = !cmp_a_dir_qual_en || i_cpu_read == cmp_a_dir_value;
  assign dir_ok_b   = !cmp_b_dir_qual_en || i_cpu_read == cmp_b_dir_value;
  // Direction value zero means write, so a write-qualified A selects the write bus.
  assign data_sel   = (cmp_a_dir_qual_en && !cmp_a_dir_value) ? i_cpu_wr_data : i_cpu_rd_data;
  assign eq_a       = i_cpu_addr == cmp_a;
  assign eq_b       = i_cpu_addr == cmp_b;
  assign eq_b_data  = data_sel == cmp_b[7:0];
  assign ge_a       = i_cpu_addr >= cmp_a;
  assign le_b       = i_cpu_addr <= cmp_b;

  // Primary condition per comparator; the range and full modes fold into A.
  assign cond_a = cmp_enable && dir_ok_a &&
                  (trigger_mode_field == MODE_INSIDE ? ge_a && le_b :
                   trigger_mode_field == MODE_OUTSIDE ? !ge_a || !le_b :
                   trigger_mode_field == MODE_A_AND_B_DATA ? eq_a && eq_b_data :
                   trigger_mode_field == MODE_A_NOT_B_DATA ? eq_a && !eq_b_data : eq_a);
  assign cond_b = cmp_enable && dir_ok_b && !full_mode && eq_b;

  // Execution tracking, one tracker per comparator so both can be in flight.
  logic hit_a;
  logic hit_b;
  logic qual_a;
  logic qual_b;

  otd_opcode_tracker #(.DEPTH(TRACK_DEPTH)) u_track_a (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_fetch   (i_opcode_fetch),
    .i_match   (cond_a),
    .i_exec    (i_opcode_exec),
    .i_flush   (i_queue_flush),
    .o_hit     (hit_a)
  );

  otd_opcode_tracker #(.DEPTH(TRACK_DEPTH)) u_track_b (
    .i_sys_clk (i_sys_clk),
    .i_reset   (i_reset),
    .i_fetch   (i_opcode_fetch),
    .i_match   (cond_b),
    .i_exec    (i_opcode_exec),
    .i_flush   (i_queue_flush),
    .o_hit     (hit_b)
  );

  assign qual_a = exec_qualify_select ? hit_a : cond_a;
  assign qual_b = exec_qualify_select ? hit_b : cond_b;

  // Trigger per mode; the sequence modes need A seen first.
  logic trigger;
  assign trigger = run_active_flag &&
                   ((trigger_mode_field == MODE_A_OR_B) ? qual_a || qual_b :
                    (trigger_mode_field == MODE_A_THEN_B ||
                     trigger_mode_field == MODE_A_THEN_EVT_B) ? qual_b && a_flag :
                    (trigger_mode_field == MODE_EVENT_B) ? qual_b : qual_a);

  // Change-of-flow address selection; unconditional branches store nothing.
  logic        cof_store;
  logic [15:0] cof_addr;
  assign cof_store = i_cof_valid && i_cof_kind != COF_UNCOND;
  assign cof_addr  = (i_cof_kind == COF_COND_TAKEN) ? i_opcode_addr :
                     (i_cof_kind == COF_INDIRECT) ? i_index_pair : i_cof_dest;

  // Queue push source. Event modes keep only the data byte in the low half.
  logic        end_trace;
  logic        capturing;
  logic        push;
  logic [15:0] push_data;
  logic        queue_full;
  logic [15:0] queue_head;
  logic [COUNT_W-1:0] valid_entry_count;

  // Event modes always run as begin traces, whatever the begin control says.
  assign end_trace  = !begin_sel && !event_mode;
  assign capturing  = run_state == RUN_CAPTURE && holdoff == 2'h0;
  assign queue_full = valid_entry_count == COUNT_W'(QUEUE_DEPTH);
  // A flow change on the start trigger or within the holdoff is lost to the pipeline.
  assign push = !run_active_flag ? rd_queue_lo :
                event_mode ? trigger :
                end_trace ? cof_store :
                capturing && cof_store;
  assign push_data = !run_active_flag ? last_fetch_addr :
                     event_mode ? {8'h00, data_sel} : cof_addr;

  otd_trace_queue #(.DEPTH(QUEUE_DEPTH), .WIDTH(16), .CW(COUNT_W)) u_queue (
    .i_sys_clk     (i_sys_clk),
    .i_reset       (i_reset),
    .i_clear_count (arm_write),
    .i_push        (push),
    .i_push_data   (push_data),
    .i_pop         (rd_queue_lo),
    .o_head        (queue_head),
    .o_count       (valid_entry_count)
  );

  // Run control: arming starts a run, which ends on its trigger, a full queue or a disarm.
  logic run_end;
  assign run_end = disarm_write ||
                   (end_trace && trigger) ||
                   (!end_trace && queue_full && run_state == RUN_CAPTURE);

  // Run flag and state; arming clears the match flags and the count.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      run_active_flag <= 1'b0;
      run_state       <= RUN_IDLE;
    end
    else if (arm_write)
    begin
      run_active_flag <= 1'b1;
      run_state       <= RUN_WAIT;
    end
    else if (run_active_flag && run_end)
    begin
      run_active_flag <= 1'b0;
      run_state       <= RUN_IDLE;
    end
    else if (run_state == RUN_WAIT && !end_trace && !event_mode && trigger)
      run_state <= RUN_CAPTURE;
    else if (run_state == RUN_WAIT && event_mode)
      run_state <= RUN_CAPTURE;
  end

  // Skip window after a begin trigger, counted in CPU bus cycles.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || arm_write)
      holdoff <= 2'h0;
    else if (run_state == RUN_WAIT && !end_trace && !event_mode && trigger)
      holdoff <= HOLDOFF_CYCLES;
    else if (holdoff != 2'h0 && i_cpu_bus_valid)
      holdoff <= holdoff - 2'h1;
  end

  // Sticky match flags; a match in the arming cycle survives the clear only when re-arming an active run.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      a_flag <= 1'b0;
      b_flag <= 1'b0;
    end
    else
    begin
      a_flag <= (run_active_flag && qual_a) || (a_flag && !arm_write);
      b_flag <= (run_active_flag && qual_b) || (b_flag && !arm_write);
    end
  end

  // Remember the last fetched opcode address for profiling.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      last_fetch_addr <= 16'h0000;
    else if (i_opcode_fetch)
      last_fetch_addr <= i_cpu_addr;
  end

  // Configuration registers, written one byte at a time on lane 0.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      cmp_a              <= CMP_RST;
      cmp_b              <= CMP_RST;
      control            <= CONTROL_RST;
      trigger_config_reg <= TRIGGER_CFG_RST;
    end
    else
    begin
      if (wr_cmp_a_hi)
        cmp_a[15:8] <= i_wb_dat[7:0];
      if (wr_cmp_a_lo)
        cmp_a[7:0] <= i_wb_dat[7:0];
      if (wr_cmp_b_hi)
        cmp_b[15:8] <= i_wb_dat[7:0];
      if (wr_cmp_b_lo)
        cmp_b[7:0] <= i_wb_dat[7:0];
      if (wr_control)
        control <= i_wb_dat[7:0];
      if (wr_trigger)
        trigger_config_reg <= i_wb_dat[7:0];
    end
  end

  // Breakpoint requests, one-cycle pulses; the core finishes or tags as its kind says.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_brk_force <= 1'b0;
      o_brk_tag   <= 1'b0;
    end
    else
    begin
      o_brk_force <= brk_en && !brk_tag_sel && trigger;
      o_brk_tag   <= brk_en && brk_tag_sel && trigger && i_opcode_fetch;
    end
  end

  // Read multiplexer; unmapped words read as zero.
  logic [7:0] rd_byte;
  logic [7:0] status;
  logic [7:0] control_view;
  assign status = {a_flag, b_flag, run_active_flag, 1'b0, valid_entry_count};
  assign control_view = {run_active_flag, control[6:0]};
  assign rd_byte = (word == OFF_CMP_A_HI[7:2])    ? cmp_a[15:8] :
                   (word == OFF_CMP_A_LO[7:2])    ? cmp_a[7:0] :
                   (word == OFF_CMP_B_HI[7:2])    ? cmp_b[15:8] :
                   (word == OFF_CMP_B_LO[7:2])    ? cmp_b[7:0] :
                   (word == OFF_QUEUE_HI[7:2])    ? queue_head[15:8] :
                   (word == OFF_QUEUE_LO[7:2])    ? queue_head[7:0] :
                   (word == OFF_CONTROL[7:2])     ? control_view :
                   (word == OFF_TRIGGER_CFG[7:2]) ? trigger_config_reg :
                   (word == OFF_STATUS[7:2])      ? status : 8'h00;

  // Bus answer one cycle after the request; data latched with ack.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
    begin
      o_wb_ack     <= 1'b0;
      o_wb_dat     <= 32'h00000000;
      o_run_active <= 1'b0;
    end
    else
    begin
      o_wb_ack     <= bus_req && !o_wb_ack;
      o_wb_dat     <= {24'h000000, rd_byte};
      o_run_active <= run_active_flag;
    end
  end

endmodule
`default_nettype wire

/* File: src/otd_pkg.sv */
package otd_pkg;

  // Byte offsets; each register takes one aligned word.
  localparam logic [7:0] OFF_CMP_A_HI      = 8'h00;
  localparam logic [7:0] OFF_CMP_A_LO      = 8'h04;
  localparam logic [7:0] OFF_CMP_B_HI      = 8'h08;
  localparam logic [7:0] OFF_CMP_B_LO      = 8'h0C;
  localparam logic [7:0] OFF_QUEUE_HI      = 8'h10;
  localparam logic [7:0] OFF_QUEUE_LO      = 8'h14;
  localparam logic [7:0] OFF_CONTROL       = 8'h18;
  localparam logic [7:0] OFF_TRIGGER_CFG   = 8'h1C;
  localparam logic [7:0] OFF_STATUS        = 8'h20;

  // Control register bit positions.
  localparam int CTL_ARM_BIT    = 7;
  localparam int CTL_BRK_EN_BIT = 6;
  localparam int CTL_TAG_BIT    = 5;
  localparam int CTL_A_DIR_EN   = 3;
  localparam int CTL_A_DIR_VAL  = 2;
  localparam int CTL_B_DIR_EN   = 1;
  localparam int CTL_B_DIR_VAL  = 0;

  // Trigger configuration register bit positions; mode field sits in bits 3..0.
  localparam int TCF_EXEC_QUAL_BIT = 7;
  localparam int TCF_BEGIN_BIT     = 6;
  localparam int TCF_MODE_MSB      = 3;

  // Status register bit positions; entry count sits in bits 3..0.
  localparam int STS_A_FLAG_BIT = 7;
  localparam int STS_B_FLAG_BIT = 6;
  localparam int STS_RUN_BIT    = 5;

  // Reset values.
  localparam logic [7:0]  CONTROL_RST     = 8'h00;
  localparam logic [7:0]  TRIGGER_CFG_RST = 8'h00;
  localparam logic [15:0] CMP_RST         = 16'h0000;

  // Trigger mode encodings of the 4-bit mode field.
  localparam logic [3:0] MODE_A_ONLY       = 4'h0;
  localparam logic [3:0] MODE_A_OR_B       = 4'h1;
  localparam logic [3:0] MODE_A_THEN_B     = 4'h2;
  localparam logic [3:0] MODE_EVENT_B      = 4'h3;
  localparam logic [3:0] MODE_A_THEN_EVT_B = 4'h4;
  localparam logic [3:0] MODE_A_AND_B_DATA = 4'h5;
  localparam logic [3:0] MODE_A_NOT_B_DATA = 4'h6;
  localparam logic [3:0] MODE_INSIDE       = 4'h7;
  localparam logic [3:0] MODE_OUTSIDE      = 4'h8;

  // Change-of-flow kinds reported by the CPU core.
  localparam logic [1:0] COF_COND_TAKEN = 2'h0;
  localparam logic [1:0] COF_UNCOND     = 2'h1;
  localparam logic [1:0] COF_INDIRECT   = 2'h2;
  localparam logic [1:0] COF_DEST       = 2'h3;

  // Queue geometry and capture pipeline holdoff.
  localparam int         QUEUE_DEPTH    = 8;
  localparam int         COUNT_W        = 4;
  localparam int         TRACK_DEPTH    = 4;
  localparam logic [1:0] HOLDOFF_CYCLES = 2'h2;

  // Run state of the capture engine.
  typedef enum logic [1:0] {RUN_IDLE, RUN_WAIT, RUN_CAPTURE} otd_run_t;

endpackage

/* File: src/otd_trace_queue.sv */
`timescale 1ns/100ps
`default_nettype none
// Shift-register capture queue: new words enter at the tail, the head is the read port.
module otd_trace_queue
  import otd_pkg::*;
#(
  parameter int DEPTH = QUEUE_DEPTH,
  parameter int WIDTH = 16,
  parameter int CW    = COUNT_W
)(
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset,
  input  wire logic             i_clear_count,
  input  wire logic             i_push,
  input  wire logic [WIDTH-1:0] i_push_data,
  input  wire logic             i_pop,
  output logic      [WIDTH-1:0] o_head,
  output logic      [CW-1:0]    o_count
);

  logic [WIDTH-1:0] chain [DEPTH+1];   // Entry i takes chain[i+1] on a shift.
  logic             shift;             // Both a push and a pop move every entry one place.
  logic [CW-1:0]    next_count;        // Valid-word count after this edge.

  // A pop alone shifts in zero, which is why a part-filled queue needs dummy reads.
  assign shift        = i_push | i_pop;
  assign chain[DEPTH] = i_push ? i_push_data : '0;
  assign o_head       = chain[0];

  // Count saturates at the depth; a push and a pop together leave it alone.
  assign next_count = i_clear_count ? '0 :
                      (i_push && !i_pop && o_count != CW'(DEPTH)) ? o_count + 1'b1 :
                      (i_pop && !i_push && o_count != '0) ? o_count - 1'b1 : o_count;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_entry
      // Each entry reloads from its neighbour toward the tail on a shift.
      always_ff @(posedge i_sys_clk)
      begin
        if (i_reset)
          chain[g] <= '0;
        else if (shift)
          chain[g] <= chain[g+1];
      end
    end
  endgenerate

  // Count register.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset)
      o_count <= '0;
    else
      o_count <= next_count;
  end

endmodule
`default_nettype wire

/* File: src/otd_opcode_tracker.sv */
`timescale 1ns/100ps
`default_nettype none
// Follows a match mark through the instruction queue and reports it only on execution.
module otd_opcode_tracker
  import otd_pkg::*;
#(
  parameter int DEPTH = TRACK_DEPTH
)(
  input  wire logic i_sys_clk,
  input  wire logic i_reset,
  input  wire logic i_fetch,
  input  wire logic i_match,
  input  wire logic i_exec,
  input  wire logic i_flush,
  output logic      o_hit
);

  localparam int CW = $clog2(DEPTH + 1);

  logic          tag [DEPTH+1];   // Mark per queued opcode; tag[DEPTH] is a constant zero.
  logic [CW-1:0] cnt;             // Opcodes currently held in the queue.
  logic          pop;             // The head opcode executes this cycle.
  logic          push;            // A fetched opcode enters this cycle.
  logic [CW-1:0] push_idx;        // Slot the fetched opcode lands in after any pop.

  assign tag[DEPTH] = 1'b0;
  assign pop        = i_exec && cnt != '0;
  assign push       = i_fetch && (cnt != CW'(DEPTH) || pop);
  assign push_idx   = pop ? cnt - 1'b1 : cnt;
  // A flush also masks a hit from the head in the same cycle, so discarded marks never report.
  assign o_hit      = pop && tag[0] && !i_flush;

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++)
    begin : g_slot
      // A slot takes the new mark, moves toward the head on execution, or holds.
      always_ff @(posedge i_sys_clk)
      begin
        if (i_reset || i_flush)
          tag[g] <= 1'b0;
        else if (push && push_idx == CW'(g))
          tag[g] <= i_match;
        else if (pop)
          tag[g] <= tag[g+1];
      end
    end
  endgenerate

  // Occupancy follows fetches and executions; a flush empties the queue.
  always_ff @(posedge i_sys_clk)
  begin
    if (i_reset || i_flush)
      cnt <= '0;
    else
      cnt <= cnt + CW'(push) - CW'(pop);
  end

endmodule
`default_nettype wire

/* File: testbench/otd_cpu_model.sv */
`timescale 1ns/100ps
`default_nettype none
// CPU core stand-in: one bus cycle per call, then the bus is released.
module otd_cpu_model (
  input  wire logic        i_sys_clk,
  output logic             o_valid,
  output logic [15:0]      o_addr,
  output logic             o_fetch,
  output logic             o_cof,
  output logic [1:0]       o_kind,
  output logic             o_bdc
);
  initial {o_valid, o_addr, o_fetch, o_cof, o_kind, o_bdc} = '0;
  // An idle bus shows the inverse address, so a stale value can never match a comparator.
  task automatic cycle(input logic [15:0] a, input logic f, input logic c, input logic [1:0] k, input logic b);
    @(posedge i_sys_clk);
    {o_valid, o_addr, o_fetch, o_cof, o_kind, o_bdc} <= {1'b1, a, f, c, k, b};
    @(posedge i_sys_clk);
    {o_valid, o_addr, o_fetch, o_cof, o_kind, o_bdc} <= {1'b0, ~a, 5'h00};
  endtask
endmodule
`default_nettype wire

/* File: testbench/otd_debug_trace_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
// Port checks on the register bus and the break requests.
module otd_debug_trace_monitor
  import otd_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  input  wire logic        o_wb_ack,
  input  wire logic [31:0] o_wb_dat,
  input  wire logic        i_cpu_bus_valid,
  input  wire logic        i_bdc_access,
  input  wire logic        i_opcode_fetch,
  input  wire logic        o_brk_force,
  input  wire logic        o_brk_tag,
  input  wire logic        o_run_active
);
  // A control write that takes effect at this edge.
  wire ctl_wr = o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr[7:2] == OFF_CONTROL[7:2];
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);
  chk_ack_one_late: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack) else $error("late ack");
  chk_ack_single_pulse: assert property (o_wb_ack |=> !o_wb_ack) else $error("long ack");
  chk_ack_has_cause: assert property (o_wb_ack |-> $past(i_wb_cyc && i_wb_stb)) else $error("stray ack");
  chk_read_upper_zero: assert property (o_wb_ack |-> o_wb_dat[31:8] == 24'h0) else $error("upper bits");
  chk_unmapped_zero: assert property (o_wb_ack && !i_wb_we && i_wb_adr[7:2] > OFF_STATUS[7:2]
    |-> o_wb_dat == 32'h0) else $error("unmapped data");
  chk_bdc_no_break: assert property (i_cpu_bus_valid && i_bdc_access |=> !o_brk_force && !o_brk_tag)
    else $error("masked break");
  chk_break_has_cause: assert property (o_brk_force |-> $past(i_cpu_bus_valid && !i_bdc_access))
    else $error("stray force");
  chk_tag_on_fetch: assert property (o_brk_tag |-> $past(i_opcode_fetch)) else $error("stray tag");
  chk_disarm_stops: assert property (ctl_wr && !i_wb_dat[CTL_ARM_BIT] |-> ##2 !o_run_active)
    else $error("disarm");
  chk_arm_starts: assert property (ctl_wr && i_wb_dat[CTL_ARM_BIT] && !i_cpu_bus_valid ##1 !i_cpu_bus_valid
    |-> ##1 o_run_active) else $error("arm");
endmodule
bind otd_debug_trace otd_debug_trace_monitor otd_debug_trace_monitor_i (.i_sys_clk(i_sys_clk),
  .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
  .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_ack(o_wb_ack), .o_wb_dat(o_wb_dat),
  .i_cpu_bus_valid(i_cpu_bus_valid), .i_bdc_access(i_bdc_access), .i_opcode_fetch(i_opcode_fetch),
  .o_brk_force(o_brk_force), .o_brk_tag(o_brk_tag), .o_run_active(o_run_active));
`default_nettype wire

/* File: testbench/tb_otd_debug_trace.sv */
`timescale 1ns/100ps
`default_nettype none
// Register-level test of the trace block beside a CPU stand-in.
module tb_otd_debug_trace
  import otd_pkg::*;
;
  logic        i_sys_clk = 1'b0, i_reset = 1'b1; // Reset is held for five cycles.
  logic        cyc = 1'b0, we = 1'b0;            // The cyc strobe also drives stb.
  logic [7:0]  adr = 8'h00, q, hi;               // Address and the last bytes read.
  logic [31:0] dat = '0, rdat;
  logic        ack, brk_f, brk_t, run, c_valid, c_fetch, c_cof, c_bdc;
  logic [15:0] c_addr, a, expq[$];               // The queue holds the words the trace should hold.
  logic [1:0]  c_kind;
  logic [7:0]  ra[4] = '{OFF_CONTROL, OFF_TRIGGER_CFG, OFF_STATUS, 8'h3C};
  int          mismatches = 0, total_checks = 0, cycles = 0;
  initial forever #25 i_sys_clk = ~i_sys_clk;
  // Side buses derive from the address so each kind stores a distinct word.
  otd_cpu_model otd_cpu_model_i (.i_sys_clk(i_sys_clk), .o_valid(c_valid), .o_addr(c_addr),
    .o_fetch(c_fetch), .o_cof(c_cof), .o_kind(c_kind), .o_bdc(c_bdc));
  otd_debug_trace otd_debug_trace_i (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_wb_cyc(cyc),
    .i_wb_stb(cyc), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'h1), .i_wb_dat(dat), .o_wb_ack(ack),
    .o_wb_dat(rdat), .i_cpu_bus_valid(c_valid), .i_cpu_addr(c_addr), .i_cpu_read(1'b1),
    .i_cpu_rd_data(c_addr[7:0]), .i_cpu_wr_data(~c_addr[7:0]), .i_bdc_access(c_bdc),
    .i_opcode_fetch(c_fetch), .i_opcode_exec(c_fetch), .i_queue_flush(1'b0),
    .i_opcode_addr(c_addr ^ 16'h1111), .i_cof_valid(c_cof), .i_cof_kind(c_kind),
    .i_index_pair(c_addr ^ 16'h2222), .i_cof_dest(c_addr ^ 16'h3333), .o_brk_force(brk_f),
    .o_brk_tag(brk_t), .o_run_active(run));
  // Word a flow change of kind k at x should leave.
  function automatic logic [15:0] dest(input logic [15:0] x, input logic [1:0] k);
    return (k == COF_COND_TAKEN) ? x ^ 16'h1111 : (k == COF_INDIRECT) ? x ^ 16'h2222 : x ^ 16'h3333;
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] ad, input logic [7:0] d);
    @(posedge i_sys_clk);
    {cyc, we, adr, dat} <= {1'b1, w, ad, 24'h0, d};
    do @(posedge i_sys_clk); while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 1'b0;
  endtask
  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge i_sys_clk);
    i_reset <= 1'b0;
    foreach (ra[i])
    begin
      wb(1'b0, ra[i], 8'h00);
      chk(q, 8'h00);
    end
    // Unarmed profiling: the first eight words only fill the queue.
    for (int i = 0; i < 9; i++)
    begin
      otd_cpu_model_i.cycle(16'hA000 + i[15:0], 1'b1, 1'b0, 2'h0, 1'b0);
      wb(1'b0, OFF_QUEUE_HI, 8'h00);
      hi = q;
      wb(1'b0, OFF_QUEUE_LO, 8'h00);
    end
    chk({hi, q}, 16'hA000);
    wb(1'b0, OFF_STATUS, 8'h00);
    chk(q, 8'h00);
    // Begin trace on A; trigger-cycle and two later flow changes are lost.
    wb(1'b1, OFF_CMP_A_HI, 8'h40);
    wb(1'b1, OFF_TRIGGER_CFG, 8'h40);
    wb(1'b1, OFF_CONTROL, 8'h80);
    for (int i = 0; i < 14; i++)
    begin
      a = (i == 0) ? 16'h4000 : 16'h2000 + i[15:0];
      otd_cpu_model_i.cycle(a, 1'b0, 1'b1, i[1:0], 1'b0);
      if (i > 2 && i[1:0] != COF_UNCOND && expq.size() < 8)
        expq.push_back(dest(a, i[1:0]));
    end
    wb(1'b0, OFF_STATUS, 8'h00);
    chk(q, 8'h88);
    foreach (expq[i])
    begin
      wb(1'b0, OFF_QUEUE_HI, 8'h00);
      hi = q;
      wb(1'b0, OFF_QUEUE_LO, 8'h00);
      chk({hi, q}, expq[i]);
    end
    // Force, then tag, each followed by a masked background access.
    for (int t = 0; t < 2; t++)
    begin
      wb(1'b1, OFF_CONTROL, 8'hC0 | 8'(t << 5));
      otd_cpu_model_i.cycle(16'h4000, 1'b1, 1'b0, 2'h0, 1'b0);
      #1 chk({brk_f, brk_t}, t ? 2'b01 : 2'b10);
      otd_cpu_model_i.cycle(16'h4000, 1'b1, 1'b0, 2'h0, 1'b1);
      #1 chk({brk_f, brk_t}, 2'b00);
    end
    wb(1'b1, OFF_CONTROL, 8'h00);
    give_verdict();
  end
  // A hang ends the run as a mismatch.
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      give_verdict();
    end
  end
endmodule
`default_nettype wire
